// ### hdl/cycle_and_event_counters.v
`timescale 1ns/1ns
`default_nettype none
`include "event_counters_consts.vh"
module cycle_and_event_counters #(
   parameter CNT_WIDTH = 48
) (
   input wire CLK,
   input wire SYS_RST,
   input wire OP_VALID,
   input wire [15:0] OP_CODE,
   input wire [31:0] INDEX_GENERAL_REGISTER,
   input wire [63:0] HIGH_LOW_WRITE_PAIR,
   input wire [1:0] CURRENT_PRIVILEGE_LEVEL,
   input wire STAMP_DISABLE_FLAG,
   input wire COUNTER_READ_ENABLE_FLAG,
   input wire [127:0] EVENTS,
   output reg [63:0] HIGH_LOW_RESULT_PAIR,
   output reg RESULT_VALID,
   output reg PROTECTION_FAULT,
   output reg MONITOR_PIN_ZERO,
   output reg MONITOR_PIN_ONE
);
   reg [63:0] stamp_q;
   reg [63:0] ctrl_q;
   reg [63:0] result_d;
   reg valid_d;
   reg fault_d;
   wire [CNT_WIDTH-1:0] cnt0;
   wire [CNT_WIDTH-1:0] cnt1;
   wire pin0;
   wire pin1;
   wire is_level0;
   wire wr_ok;
   wire [64:0] stamp_inc;

   function [63:0] widen;
      input [CNT_WIDTH-1:0] v;
      begin
         widen = {{(64-CNT_WIDTH){1'b0}}, v};
      end
   endfunction

   assign is_level0 = CURRENT_PRIVILEGE_LEVEL == `LEVEL_ZERO;
   assign wr_ok = OP_VALID & (OP_CODE == `OP_MODEL_WRITE) & is_level0; // [RQ3] [RQ4]
   assign stamp_inc = {1'b0, stamp_q} + 65'h0_0000_0000_0000_0001;

   // Free-running on core clock; no suspend input gates it [RQ5] [RQ6]
   always @(posedge CLK) begin
      if (SYS_RST) begin
         stamp_q <= 64'h0000_0000_0000_0000;
         ctrl_q <= `CTRL_RESET; // [RQ21]
      end else begin
         if (wr_ok && INDEX_GENERAL_REGISTER == `IDX_STAMP) begin
            stamp_q <= HIGH_LOW_WRITE_PAIR; // [RQ23]
         end else begin
            stamp_q <= stamp_inc[63:0];
         end
         if (wr_ok && INDEX_GENERAL_REGISTER == `IDX_CTRL) begin
            ctrl_q <= HIGH_LOW_WRITE_PAIR & `CTRL_MASK; // [RQ19]
         end
      end
   end

   // Counter fields from the shared control word [RQ9] [RQ20] [RQ21]
   event_counter_unit #(
      .WIDTH(CNT_WIDTH)
   ) u_cnt0 (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .ctrl(ctrl_q[10:0]),
      .level(CURRENT_PRIVILEGE_LEVEL),
      .event_vec(EVENTS),
      .load(wr_ok && INDEX_GENERAL_REGISTER == `IDX_CNT0),
      .load_value(HIGH_LOW_WRITE_PAIR[CNT_WIDTH-1:0]),
      .count_q(cnt0),
      .pin_q(pin0)
   );

   event_counter_unit #(
      .WIDTH(CNT_WIDTH)
   ) u_cnt1 (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .ctrl(ctrl_q[`C1_BASE+10:`C1_BASE]),
      .level(CURRENT_PRIVILEGE_LEVEL),
      .event_vec(EVENTS),
      .load(wr_ok && INDEX_GENERAL_REGISTER == `IDX_CNT1),
      .load_value(HIGH_LOW_WRITE_PAIR[CNT_WIDTH-1:0]),
      .count_q(cnt1),
      .pin_q(pin1)
   );

   // Reads return pre-edge values; a fault returns zero data
   always @* begin
      result_d = 64'h0000_0000_0000_0000;
      valid_d = 1'b0;
      fault_d = 1'b0;
      if (OP_VALID) begin
         case (OP_CODE)
            `OP_MODEL_READ: begin
               if (!is_level0) begin
                  fault_d = 1'b1; // [RQ4] [RQ24]
               end else begin
                  valid_d = 1'b1;
                  case (INDEX_GENERAL_REGISTER)
                     `IDX_STAMP: result_d = stamp_q; // [RQ1] [RQ2]
                     `IDX_CTRL: result_d = ctrl_q;
                     `IDX_CNT0: result_d = widen(cnt0);
                     `IDX_CNT1: result_d = widen(cnt1);
                     default: begin
                        valid_d = 1'b0;
                        fault_d = 1'b1;
                     end
                  endcase
               end
            end
            `OP_MODEL_WRITE: begin
               case (INDEX_GENERAL_REGISTER)
                  `IDX_STAMP, `IDX_CTRL, `IDX_CNT0, `IDX_CNT1: begin
                     valid_d = is_level0;
                     fault_d = ~is_level0; // [RQ24]
                  end
                  default: fault_d = 1'b1;
               endcase
            end
            `OP_STAMP_READ: begin
               if (STAMP_DISABLE_FLAG && !is_level0) begin
                  fault_d = 1'b1; // [RQ8] [RQ24]
               end else begin
                  valid_d = 1'b1;
                  result_d = stamp_q; // [RQ7]
               end
            end
            `OP_COUNTER_READ: begin
               if (!COUNTER_READ_ENABLE_FLAG && !is_level0) begin
                  fault_d = 1'b1; // [RQ12] [RQ24]
               end else if (INDEX_GENERAL_REGISTER == 32'h0000_0000) begin
                  valid_d = 1'b1;
                  result_d = widen(cnt0); // [RQ11]
               end else if (INDEX_GENERAL_REGISTER == 32'h0000_0001) begin
                  valid_d = 1'b1;
                  result_d = widen(cnt1); // [RQ11]
               end else begin
                  fault_d = 1'b1;
               end
            end
            default: begin
               valid_d = 1'b0;
            end
         endcase
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         HIGH_LOW_RESULT_PAIR <= 64'h0000_0000_0000_0000;
         RESULT_VALID <= 1'b0;
         PROTECTION_FAULT <= 1'b0;
         MONITOR_PIN_ZERO <= 1'b0;
         MONITOR_PIN_ONE <= 1'b0;
      end else begin
         HIGH_LOW_RESULT_PAIR <= result_d;
         RESULT_VALID <= valid_d;
         PROTECTION_FAULT <= fault_d;
         MONITOR_PIN_ZERO <= pin0; // [RQ13]
         MONITOR_PIN_ONE <= pin1; // [RQ13]
      end
   end
endmodule
`default_nettype wire

// ### hdl/event_counters_consts.vh
// Summary of operation
// (RQ1) Four 64-bit registers at indices 10h..13h: stamp, control, counter 0, counter 1.
// (RQ2) Model read op 0F32h returns register chosen by index into high:low pair.
// (RQ3) Model write op 0F30h loads high:low pair into register chosen by index.
// (RQ4) Model read and write ops only allowed at privilege level 0.
// (RQ5) Stamp counter is 64 bits, increments every core clock since reset.
// (RQ6) Stamp counter keeps counting in suspend and shutdown.
// (RQ7) Stamp read op 0F31h returns full stamp counter value.
// (RQ8) Stamp disable flag 1 restricts stamp read to level 0; 0 allows any.
// (RQ9) Two independent 48-bit event counters share one control register.
// (RQ10) Event counters keep counting in suspend and shutdown.
// (RQ11) Counter read op 0F33h returns event counter chosen by index.
// (RQ12) Counter read enable 1 allows any level; 0 restricts to level 0.
// (RQ13) Per-counter pin mode picks overflow or event indication on monitor pin.
// (RQ14) Event mode: pin asserts in any cycle with one or more events.
// (RQ15) Overflow mode: pin asserts when the preset counter overflows.
// (RQ16) Type bit selects counting clocks (timer) or counting selected events.
// (RQ17) One gate enables counting below level 3, other at level 3.
// (RQ18) Both gates set counts always; neither set never counts.
// (RQ19) Control register at 11h holds separate fields for each counter.
// (RQ20) Counter 1: pin mode 25, type 24, gates 23/22, code 26 and 21-16.
// (RQ21) Counter 0: pin mode 9, type 8, gates 7/6, code 10 and 5-0; reset 0.
// (RQ22) Duration events count every cycle; event-mode pin held throughout.
// (RQ23) Writes replace counts; counting continues; counters wrap past maximum.
// (RQ24) Unprivileged gated access raises protection fault, transfers no data.
`ifndef EVENT_COUNTERS_CONSTS_VH
`define EVENT_COUNTERS_CONSTS_VH
`define IDX_STAMP 32'h0000_0010
`define IDX_CTRL 32'h0000_0011
`define IDX_CNT0 32'h0000_0012
`define IDX_CNT1 32'h0000_0013
`define OP_MODEL_WRITE 16'h0F30
`define OP_STAMP_READ 16'h0F31
`define OP_MODEL_READ 16'h0F32
`define OP_COUNTER_READ 16'h0F33
`define C1_BASE 16
`define CODE_LO_W 6
`define F_CODE_HI 10
`define F_GATE_LOW 6
`define F_GATE_L3 7
`define F_TYPE 8
`define F_PIN_MODE 9
`define CTRL_MASK 64'h0000_0000_07FF_07FF
`define CTRL_RESET 64'h0000_0000_0000_0000
`define LEVEL_THREE 2'h3
`define LEVEL_ZERO 2'h0
`endif

// ### hdl/event_counter_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "event_counters_consts.vh"
module event_counter_unit #(
   parameter WIDTH = 48
) (
   input wire CLK,
   input wire SYS_RST,
   input wire [10:0] ctrl,
   input wire [1:0] level,
   input wire [127:0] event_vec,
   input wire load,
   input wire [WIDTH-1:0] load_value,
   output reg [WIDTH-1:0] count_q,
   output reg pin_q
);
   wire [6:0] code;
   wire gate_ok;
   wire tick;
   wire [WIDTH:0] sum;
   assign code = {ctrl[`F_CODE_HI], ctrl[`CODE_LO_W-1:0]};
   // Privilege gating [RQ17] [RQ18]
   assign gate_ok = (level == `LEVEL_THREE) ? ctrl[`F_GATE_L3] : ctrl[`F_GATE_LOW];
   // Clock type counts every cycle; duration events count each active cycle [RQ16] [RQ22]
   assign tick = gate_ok & (ctrl[`F_TYPE] | event_vec[code]);
   assign sum = {1'b0, count_q} + {{WIDTH{1'b0}}, tick};
   always @(posedge CLK) begin
      if (SYS_RST) begin
         count_q <= {WIDTH{1'b0}};
         pin_q <= 1'b0;
      end else begin
         if (load) begin
            count_q <= load_value; // [RQ23]
         end else begin
            count_q <= sum[WIDTH-1:0]; // Wraps to zero [RQ23] [RQ10]
         end
         // Overflow mode flags carry-out; event mode follows each counting cycle
         if (ctrl[`F_PIN_MODE]) begin
            pin_q <= ~load & sum[WIDTH]; // [RQ13] [RQ15]
         end else begin
            pin_q <= tick; // [RQ14] [RQ22]
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/cycle_and_event_counters_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "event_counters_consts.vh"
module cycle_and_event_counters_sva #(
   parameter CNT_WIDTH = 48
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic OP_VALID,
   input wire logic [15:0] OP_CODE,
   input wire logic [31:0] INDEX_GENERAL_REGISTER,
   input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
   input wire logic STAMP_DISABLE_FLAG,
   input wire logic COUNTER_READ_ENABLE_FLAG,
   input wire logic [63:0] HIGH_LOW_RESULT_PAIR,
   input wire logic RESULT_VALID,
   input wire logic PROTECTION_FAULT,
   input wire logic MONITOR_PIN_ZERO,
   input wire logic MONITOR_PIN_ONE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire unpriv = CURRENT_PRIVILEGE_LEVEL != `LEVEL_ZERO;
   wire known = OP_VALID && OP_CODE[15:2] == 14'h03CC;
   sequence s_stamp;
      RESULT_VALID && $past(OP_VALID) && $past(OP_CODE) == `OP_STAMP_READ;
   endsequence
   chk_one_answer: assert property (known |=> RESULT_VALID != PROTECTION_FAULT)
      else $error("op without single answer");
   chk_model_priv: assert property (known && !OP_CODE[0] && unpriv |=> PROTECTION_FAULT)
      else $error("model op not refused");
   chk_stamp_gate: assert property (OP_VALID && OP_CODE == `OP_STAMP_READ |=>
      PROTECTION_FAULT == ($past(STAMP_DISABLE_FLAG) && $past(unpriv)))
      else $error("stamp gate wrong");
   chk_read_gate: assert property (OP_VALID && OP_CODE == `OP_COUNTER_READ &&
      INDEX_GENERAL_REGISTER < 32'h0000_0002 |=>
      PROTECTION_FAULT == (!$past(COUNTER_READ_ENABLE_FLAG) && $past(unpriv)))
      else $error("read gate wrong");
   chk_fault_no_data: assert property (PROTECTION_FAULT |->
      !RESULT_VALID && HIGH_LOW_RESULT_PAIR == 64'h0000_0000_0000_0000) else $error("fault data");
   chk_stamp_step: assert property (s_stamp ##1 !RESULT_VALID ##1 s_stamp |->
      HIGH_LOW_RESULT_PAIR == $past(HIGH_LOW_RESULT_PAIR, 2) + 64'h0000_0000_0000_0002)
      else $error("stamp step wrong");
   chk_wide_zero: assert property (RESULT_VALID && $past(OP_CODE) == `OP_COUNTER_READ |->
      HIGH_LOW_RESULT_PAIR[63:CNT_WIDTH] == '0) else $error("counter upper bits set");
   chk_reset_quiet: assert property (disable iff (1'b0) SYS_RST |=>
      !(RESULT_VALID || PROTECTION_FAULT || MONITOR_PIN_ZERO || MONITOR_PIN_ONE))
      else $error("outputs active after reset");
   cover property (PROTECTION_FAULT);
   cover property (MONITOR_PIN_ZERO);
   cover property (s_stamp ##1 !RESULT_VALID ##1 s_stamp);
endmodule
bind cycle_and_event_counters cycle_and_event_counters_sva #(.CNT_WIDTH(CNT_WIDTH)) u_sva (
   .CLK(CLK), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
   .INDEX_GENERAL_REGISTER(INDEX_GENERAL_REGISTER),
   .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL),
   .STAMP_DISABLE_FLAG(STAMP_DISABLE_FLAG),
   .COUNTER_READ_ENABLE_FLAG(COUNTER_READ_ENABLE_FLAG),
   .HIGH_LOW_RESULT_PAIR(HIGH_LOW_RESULT_PAIR), .RESULT_VALID(RESULT_VALID),
   .PROTECTION_FAULT(PROTECTION_FAULT), .MONITOR_PIN_ZERO(MONITOR_PIN_ZERO),
   .MONITOR_PIN_ONE(MONITOR_PIN_ONE));
`default_nettype wire

// ### tb/event_source.sv
`timescale 1ns/1ns
`default_nettype none
module event_source (
   input wire logic clk,
   input wire logic [6:0] code,
   input wire logic ev_on,
   output logic [127:0] events
);
   logic on_q;
   logic [127:0] nxt;
   initial events = {128{1'b0}};
   // Unselected lines toggle so a wrong code decode shows up
   // Built in a scratch word so the lines change once per cycle
   always @(posedge clk) begin
      on_q = ev_on;
      #1;
      nxt = {64{~events[1], events[1]}};
      nxt[code] = on_q;
      events = nxt;
   end
endmodule
`default_nettype wire

// ### tb/cycle_and_event_counters_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "event_counters_consts.vh"
module cycle_and_event_counters_tb_top;
   localparam logic [63:0] z64 = 64'h0000_0000_0000_0000;
   localparam logic [31:0] z32 = 32'h0000_0000;
   logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, dis = 1'b0, ena = 1'b0, ev_on = 1'b0;
   logic [15:0] op_code = 16'h0000;
   logic [31:0] idx = z32;
   logic [63:0] wdata = z64, got;
   logic [1:0] lvl = 2'h0;
   logic got_pf, got_p0, got_rv;
   wire [127:0] events;
   wire [63:0] res;
   wire rv, pf, pin0, pin1;
   int num_errors = 0, num_checks = 0, k, p1_cnt = 0;
   cycle_and_event_counters u_cycle_and_event_counters (.CLK(clk), .SYS_RST(rst),
      .OP_VALID(op_valid), .OP_CODE(op_code), .INDEX_GENERAL_REGISTER(idx),
      .HIGH_LOW_WRITE_PAIR(wdata), .CURRENT_PRIVILEGE_LEVEL(lvl), .STAMP_DISABLE_FLAG(dis),
      .COUNTER_READ_ENABLE_FLAG(ena), .EVENTS(events), .HIGH_LOW_RESULT_PAIR(res),
      .RESULT_VALID(rv), .PROTECTION_FAULT(pf), .MONITOR_PIN_ZERO(pin0), .MONITOR_PIN_ONE(pin1));
   event_source u_event_source (.clk(clk), .code(7'h05), .ev_on(ev_on), .events(events));
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic op(input logic [15:0] c, input logic [31:0] i, input logic [63:0] d);
      @(posedge clk) #1;
      op_valid = 1'b1;
      op_code = c;
      idx = i;
      wdata = d;
      @(posedge clk) #1;
      op_valid = 1'b0;
      got = res;
      got_pf = pf;
      got_p0 = pin0;
      got_rv = rv;
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (pin1 === 1'b1) p1_cnt++;
   initial begin
      #4000;
      num_errors++;
      conclude;
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      for (k = 0; k < 3; k++) begin
         op(`OP_MODEL_READ, 32'(`IDX_CTRL + k), z64);
         chk("reset value", got, z64);
      end
      op(`OP_MODEL_READ, 32'h0000_0014, z64);
      chk("unmapped index", got_pf, 1'b1);
      op(`OP_MODEL_WRITE, `IDX_CTRL, 64'hFFFF_FFFF_FFFF_FFFF);
      chk("write done", got_rv, 1'b1);
      op(`OP_MODEL_READ, `IDX_CTRL, z64);
      chk("control mask", got, `CTRL_MASK);
      op(`OP_MODEL_WRITE, `IDX_STAMP, 64'hFFFF_FFFF_FFFF_FFFF);
      op(`OP_STAMP_READ, z32, z64);
      chk("stamp wrap", got, z64);
      op(`OP_STAMP_READ, z32, z64);
      chk("stamp step", got, 64'h0000_0000_0000_0002);
      op(`OP_MODEL_WRITE, `IDX_CTRL, 64'h0000_0000_00C5_0340);
      op(`OP_MODEL_WRITE, `IDX_CNT0, 64'h0000_FFFF_FFFF_FFFF);
      op(`OP_COUNTER_READ, z32, z64);
      chk("timer wrap", got, z64);
      chk("overflow pin", got_p0, 1'b1);
      op(`OP_MODEL_WRITE, `IDX_CNT1, z64);
      lvl = 2'h3;
      ena = 1'b1;
      ev_on = 1'b1;
      repeat (3) @(posedge clk);
      #1 ev_on = 1'b0;
      op(`OP_COUNTER_READ, 32'h0000_0001, z64);
      chk("event count", got, 64'h0000_0000_0000_0003);
      for (k = 0; k < 8; k++) begin
         lvl = k[2:1];
         dis = k[0];
         ena = k[0];
         op(`OP_STAMP_READ, z32, z64);
         chk("stamp gate", got_pf, dis && lvl != 2'h0);
         op(`OP_COUNTER_READ, z32, z64);
         chk("read gate", got_pf, !ena && lvl != 2'h0);
         op(`OP_MODEL_READ, `IDX_CNT0, z64);
         chk("model gate", got_pf, lvl != 2'h0);
         chk("model valid", got_rv, lvl == 2'h0);
      end
      chk("event pin cycles", p1_cnt, 3);
      conclude;
   end
endmodule
`default_nettype wire
